// ---- core/debug_session_control.sv ----
// debug session control: arm, immediate trigger, break routing,
// comparator bank visibility, status and event interrupt
// assumes all inputs are on clk_in; sequencer steps and trace control
// are external and report through pulses and the trace_begun_in level
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module debug_session_control #(
  parameter int LINES = debug_session_pkg::TRACE_LINES
) (
  input  wire logic       clk_in,          // 20 MHz bus clock
  input  wire logic       reset_in,        // sync reset, active high
  input  wire logic       por_in,          // power-on reset, sync, high
  input  wire logic [7:0] addr_in,         // register address
  input  wire logic [7:0] wdata_in,        // write data
  input  wire logic       wr_in,           // write strobe
  input  wire logic       rd_in,           // read strobe
  output logic      [7:0] rdata_out,       // read data, cycle after rd_in
  input  wire logic       secure_in,       // device secure
  input  wire logic       trace_source_enable_in,
  input  wire logic       trigger_alignment_in,   // 1 begin alignment
  input  wire logic       trace_begun_in,  // tracing has started
  input  wire logic       trace_done_in,   // tracing session complete
  input  wire logic       trace_line_in,   // a trace line stored
  input  wire logic       seq_step_in,     // sequencer transition
  input  wire logic [2:0] seq_step_state_in,  // state it moves to
  input  wire logic       background_mode_enable_in,
  input  wire logic       background_active_in,
  output logic            armed_out,       // session armed
  output logic      [2:0] state_out,       // sequencer_state_flags
  output logic      [1:0] bank_select_out, // comparator_bank_select
  output logic            window_sel_out,  // access hits comparator window
  output logic            shared_sel_out,  // access hits shared address
  output logic            match_view_out,  // shared address shows match flags
  output logic            trigger_out,     // trigger pulse to trace control
  output logic            background_out,  // break into background mode
  output logic            software_int_out,  // software_interrupt request
  output logic            irq_out          // event interrupt, level
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic ctrl_wr;   // write to debug_control_one
  logic mask_wr;   // write to event mask
  logic trace_on;  // tracing possible in this session
  logic arm_wr;    // write with arm set
  logic immediate_trigger_take; // accepted immediate trigger
  assign ctrl_wr  = wr_in && addr_in == debug_session_pkg::CTRL_ADDR;
  assign mask_wr  = wr_in && addr_in == debug_session_pkg::MASK_ADDR;
  assign trace_on = trace_source_enable_in && !secure_in;
  assign arm_wr   = ctrl_wr && wdata_in[debug_session_pkg::ARM_BIT];

  // ----------------------------------------------------------------
  // session state
  // ----------------------------------------------------------------
  debug_session_pkg::phase_t phase_q, phase_d;  // session phase
  logic       armed_q, armed_d;    // arm bit
  logic       route_q, route_d;    // background_route_select
  logic       brken_q, brken_d;    // final_state_break_enable
  logic [1:0] bank_q, bank_d;      // comparator_bank_select
  logic [2:0] state_q, state_d;    // sequencer_state_flags
  logic       forced_q, forced_d;  // trigger forced the final state
  logic       brk_q, brk_d;        // break request pulse
  logic       immediate_trigger_q, immediate_trigger_d;      // trigger to trace control
  logic       end_d;               // hardware ended session
  logic       brk_ok;              // break wanted at final

  // trigger ignored once begin-aligned tracing is under way; a trigger
  // write must keep the arm bit set, else it is a disarm
  assign immediate_trigger_take = arm_wr && wdata_in[debug_session_pkg::IMMEDIATE_TRIGGER_BIT] && armed_q
                     && !(trace_begun_in && trigger_alignment_in);
  assign brk_ok = brken_q || forced_q;

  // next session state: hardware events first, software write last
  always_comb begin
    phase_d  = phase_q;
    armed_d  = armed_q;
    route_d  = route_q;
    brken_d  = brken_q;
    bank_d   = bank_q;
    state_d  = state_q;
    forced_d = forced_q;
    brk_d    = 1'b0;
    immediate_trigger_d   = 1'b0;
    end_d    = 1'b0;
    unique case (phase_q)
      debug_session_pkg::PH_DISARMED: begin
        // idle, nothing to track
      end
      debug_session_pkg::PH_RUNNING: begin
        if (seq_step_in) begin
          state_d = seq_step_state_in;
          if (seq_step_state_in == debug_session_pkg::SEQ_FINAL) begin
            phase_d = debug_session_pkg::PH_FINAL;
          end
        end
      end
      debug_session_pkg::PH_FINAL: begin
        // with tracing, break and end wait for trace completion
        if (!trace_on || trace_done_in) begin
          if (brk_ok) begin
            brk_d = 1'b1;
          end
          if (brk_ok || trace_done_in) begin
            armed_d  = 1'b0;
            end_d    = 1'b1;
            phase_d  = debug_session_pkg::PH_DISARMED;
            state_d  = debug_session_pkg::SEQ_IDLE;
            forced_d = 1'b0;
          end
        end
      end
    endcase
    if (immediate_trigger_take) begin
      // jump to final at once, break forced at completion
      phase_d  = debug_session_pkg::PH_FINAL;
      state_d  = debug_session_pkg::SEQ_FINAL;
      forced_d = 1'b1;
      immediate_trigger_d   = trace_on;
    end
    if (ctrl_wr) begin
      bank_d = wdata_in[debug_session_pkg::BANK_LSB +: 2];
      // route and break enable only take writes when disarmed beforehand
      if (!armed_q) begin
        route_d = wdata_in[debug_session_pkg::ROUTE_BIT];
        brken_d = wdata_in[debug_session_pkg::BRKEN_BIT];
      end
      if (arm_wr) begin
        // a write of one while armed keeps the session so a trigger lands
        if (!armed_q) begin
          armed_d  = 1'b1;
          phase_d  = debug_session_pkg::PH_RUNNING;
          state_d  = debug_session_pkg::SEQ_FIRST;
          forced_d = 1'b0;
          immediate_trigger_d   = 1'b0;
        end
      end else if (armed_q) begin
        // software disarm keeps state flags, route and break enable
        armed_d  = 1'b0;
        phase_d  = debug_session_pkg::PH_DISARMED;
        forced_d = 1'b0;
      end
    end
  end

  // register session state; every control bit resets to zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_q  <= debug_session_pkg::PH_DISARMED;
      armed_q  <= 1'b0;
      route_q  <= 1'b0;
      brken_q  <= 1'b0;
      bank_q   <= 2'h0;
      state_q  <= debug_session_pkg::SEQ_IDLE;
      forced_q <= 1'b0;
      brk_q    <= 1'b0;
      immediate_trigger_q   <= 1'b0;
    end else begin
      phase_q  <= phase_d;
      armed_q  <= armed_d;
      route_q  <= route_d;
      brken_q  <= brken_d;
      bank_q   <= bank_d;
      state_q  <= state_d;
      forced_q <= forced_d;
      brk_q    <= brk_d;
      immediate_trigger_q   <= immediate_trigger_d;
    end
  end

  // ----------------------------------------------------------------
  // breakpoint routing and trace fill
  // ----------------------------------------------------------------
  logic trace_full;  // trace_full_flag
  break_router u_router (
    .break_in         (brk_q),
    .route_bdm_in     (route_q),
    .bdm_enable_in    (background_mode_enable_in),
    .bdm_active_in    (background_active_in),
    .background_out   (background_out),
    .software_int_out (software_int_out)
  );
  trace_fill_counter #(.LINES(LINES)) u_fill (
    .clk_in   (clk_in),
    .por_in   (por_in),
    .clear_in (arm_wr),
    .line_in  (trace_line_in),
    .full_out (trace_full)
  );

  // ----------------------------------------------------------------
  // events, mask and read port
  // ----------------------------------------------------------------
  logic [debug_session_pkg::EV_W-1:0] ev_q, ev_d;      // sticky events
  logic [debug_session_pkg::EV_W-1:0] mask_q, mask_d;  // event mask
  logic [debug_session_pkg::EV_W-1:0] ev_set;          // events this cycle
  logic [7:0] rdata_q, rdata_d;                        // read data
  logic       full_d1_q;                               // trace_full delayed

  assign ev_set = {trace_full && !full_d1_q, brk_q, end_d};

  // read clears the event bits, a new event in that cycle wins
  always_comb begin
    ev_d   = ev_q;
    mask_d = mask_q;
    if (rd_in && addr_in == debug_session_pkg::EVENT_ADDR) begin
      ev_d = '0;
    end
    ev_d = ev_d | ev_set;
    if (mask_wr && !armed_q) begin
      mask_d = wdata_in[debug_session_pkg::EV_W-1:0];
    end
  end

  // read mux: status ignores writes, trigger reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        debug_session_pkg::CTRL_ADDR: begin
          rdata_d[debug_session_pkg::ARM_BIT]   = armed_q;
          rdata_d[debug_session_pkg::ROUTE_BIT] = route_q;
          rdata_d[debug_session_pkg::BRKEN_BIT] = brken_q;
          rdata_d[debug_session_pkg::BANK_LSB +: 2] = bank_q;
        end
        debug_session_pkg::STATUS_ADDR: begin
          rdata_d[debug_session_pkg::FULL_BIT] = trace_full;
          rdata_d[2:0] = state_q;
        end
        debug_session_pkg::EVENT_ADDR: begin
          rdata_d[debug_session_pkg::EV_W-1:0] = ev_q;
        end
        debug_session_pkg::MASK_ADDR: begin
          rdata_d[debug_session_pkg::EV_W-1:0] = mask_q;
        end
        default: begin
          rdata_d = 8'h00;  // unmapped reads as zero
        end
      endcase
    end
  end

  // register events, mask and read data
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ev_q      <= '0;
      mask_q    <= '0;
      rdata_q   <= 8'h00;
      full_d1_q <= trace_full;  // full survives reset, so no false rising edge
    end else begin
      ev_q      <= ev_d;
      mask_q    <= mask_d;
      rdata_q   <= rdata_d;
      full_d1_q <= trace_full;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out       = rdata_q;
  assign armed_out       = armed_q;
  assign state_out       = state_q;
  assign bank_select_out = bank_q;
  assign window_sel_out  = addr_in >= debug_session_pkg::WINDOW_LO
                           && addr_in <= debug_session_pkg::WINDOW_HI
                           && bank_q != debug_session_pkg::BANK_NONE;
  assign shared_sel_out  = addr_in == debug_session_pkg::SHARED_ADDR;
  assign match_view_out  = bank_q == debug_session_pkg::BANK_NONE;
  assign trigger_out     = immediate_trigger_q;
  assign irq_out         = |(ev_q & mask_q);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_DISARM_KEEPS: assert property (ctrl_wr && armed_q && !arm_wr
    |=> route_q == $past(route_q) && brken_q == $past(brken_q) && !armed_q)
    else $error("disarm write changed route or break enable");
  AST_ARMED_MASK: assert property (mask_wr && armed_q |=> $stable(mask_q))
    else $error("mask written while armed");
  AST_BANK_ANYTIME: assert property (ctrl_wr |=> bank_q == $past(wdata_in[1:0]))
    else $error("bank select write lost");
  AST_AUTO_DISARM: assert property (brk_q && !$past(arm_wr) |-> !armed_q
    && state_q == debug_session_pkg::SEQ_IDLE)
    else $error("breakpoint did not end the session");
  AST_ARM_FIRST: assert property (arm_wr && !armed_q |=> armed_q && !trace_full
    && state_q == debug_session_pkg::SEQ_FIRST)
    else $error("arming did not enter first state");
  AST_IMMEDIATE_TRIGGER_ZERO: assert property (rd_in && addr_in == debug_session_pkg::CTRL_ADDR
    |=> rdata_out[debug_session_pkg::IMMEDIATE_TRIGGER_BIT] == 1'b0)
    else $error("trigger bit read back one");
  AST_IMMEDIATE_TRIGGER_GATED: assert property (trigger_out |-> $past(trace_on)
    && $past(immediate_trigger_take))
    else $error("trigger started tracing while not allowed");
  AST_IMMEDIATE_TRIGGER_FINAL: assert property (immediate_trigger_take |=> forced_q
    && state_q == debug_session_pkg::SEQ_FINAL || state_q == debug_session_pkg::SEQ_IDLE)
    else $error("trigger did not reach final state");
  AST_BREAK_CAUSE: assert property (brk_q |-> $past(brk_ok)
    && $past(phase_q) == debug_session_pkg::PH_FINAL)
    else $error("breakpoint without enable or final state");
  AST_ROUTE_BG: assert property (background_out |-> route_q
    && background_mode_enable_in && !software_int_out)
    else $error("background break without route and enable");
  AST_TRACE_WAIT: assert property (phase_q == debug_session_pkg::PH_FINAL
    && trace_on && !trace_done_in && !ctrl_wr |=> !brk_q && armed_q)
    else $error("break issued before trace completion");
  AST_STATUS_RO: assert property (wr_in && addr_in == debug_session_pkg::STATUS_ADDR
    && !seq_step_in && phase_q == debug_session_pkg::PH_RUNNING |=> $stable(state_q))
    else $error("status changed by a write");

  COV_IMMEDIATE_TRIGGER_BREAK: cover property (immediate_trigger_take ##[1:20] brk_q);
  COV_SW_DISARM: cover property (armed_q && ctrl_wr && !arm_wr);
  COV_FULL_IRQ: cover property (trace_full && irq_out);
endmodule : debug_session_control
`default_nettype wire

// ---- pkg/debug_session_pkg.sv ----
// constants shared by the debug session control block and its helpers
// assumes byte-wide registers on an 8-bit address register port
package debug_session_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h20;  // debug_control_one
  localparam logic [7:0] STATUS_ADDR = 8'h21;  // debug_status
  localparam logic [7:0] SHARED_ADDR = 8'h27;  // sequencer control / match flags
  localparam logic [7:0] WINDOW_LO   = 8'h28;  // first byte of comparator window
  localparam logic [7:0] WINDOW_HI   = 8'h2f;  // last byte of comparator window
  localparam logic [7:0] EVENT_ADDR  = 8'h30;  // sticky event status
  localparam logic [7:0] MASK_ADDR   = 8'h31;  // event mask

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int ARM_BIT   = 7;  // session arm
  localparam int IMMEDIATE_TRIGGER_BIT  = 6;  // immediate_trigger, reads zero
  localparam int ROUTE_BIT = 4;  // background_route_select
  localparam int BRKEN_BIT = 3;  // final_state_break_enable
  localparam int BANK_LSB  = 0;  // comparator_bank_select [1:0]
  localparam int FULL_BIT  = 7;  // trace_full_flag in status
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] BANK_NONE  = 2'h3;  // shows match flags at shared address

  // ----------------------------------------------------------------
  // sequencer state codes and trace depth
  // ----------------------------------------------------------------
  localparam logic [2:0] SEQ_IDLE  = 3'h0;  // disarmed
  localparam logic [2:0] SEQ_FIRST = 3'h1;  // first active state
  localparam logic [2:0] SEQ_FINAL = 3'h4;  // final state
  localparam int TRACE_LINES = 64;           // lines that make the trace full

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int EV_END   = 0;  // session ended by hardware
  localparam int EV_BREAK = 1;  // breakpoint issued
  localparam int EV_FULL  = 2;  // trace became full
  localparam int EV_W     = 3;

  // session phase
  typedef enum logic [1:0] {PH_DISARMED, PH_RUNNING, PH_FINAL} phase_t;

endpackage : debug_session_pkg

// ---- core/trace_fill_counter.sv ----
// counts stored trace lines since arming and flags a full buffer
// assumes line_in is a one-cycle pulse on clk_in; only por_in resets it
`timescale 1ns/1ps
`default_nettype none
module trace_fill_counter #(
  parameter int LINES = 64
) (
  input  wire logic clk_in,    // bus clock
  input  wire logic por_in,    // power-on reset, sync, active high
  input  wire logic clear_in,  // arm written to one
  input  wire logic line_in,   // one trace line stored
  output logic      full_out   // at least LINES lines stored
);
  localparam int CW = $clog2(LINES + 1);
  localparam logic [CW-1:0] TOP = CW'(LINES);

  logic [CW-1:0] count_q;  // saturating line count
  logic [CW-1:0] count_d;

  // saturate at the full mark so the flag cannot wrap back
  always_comb begin
    count_d = count_q;
    if (clear_in) begin
      count_d = '0;
    end else if (line_in && count_q != TOP) begin
      count_d = count_q + CW'(1);
    end
  end

  // only power-on reset clears the count; other resets keep it
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign full_out = (count_q == TOP);
endmodule : trace_fill_counter
`default_nettype wire

// ---- core/break_router.sv ----
// steers a breakpoint request to background mode or software interrupt
// assumes the background unit states are levels on the same clock
`timescale 1ns/1ps
`default_nettype none
module break_router (
  input  wire logic break_in,          // breakpoint request
  input  wire logic route_bdm_in,      // background_route_select
  input  wire logic bdm_enable_in,     // background_mode_enable
  input  wire logic bdm_active_in,     // background mode active now
  output logic      background_out,    // enter background mode
  output logic      software_int_out   // raise software_interrupt
);
  // routed to background mode only when that mode is enabled,
  // with route clear a break is dropped while background is active
  always_comb begin
    background_out   = 1'b0;
    software_int_out = 1'b0;
    if (break_in) begin
      if (route_bdm_in) begin
        background_out   = bdm_enable_in;
        software_int_out = !bdm_enable_in;
      end else begin
        software_int_out = !bdm_active_in;
      end
    end
  end
endmodule : break_router
`default_nettype wire

// ---- sim/trace_partner.sv ----
// trace control model: runs a short trace on each trigger pulse that arrives while no trace is under way
// assumes trigger_in is a one-cycle pulse on clk_in
`timescale 1ns/1ps
`default_nettype none
module trace_partner #(
  parameter int LINES = 4
) (
  input  wire logic clk_in,     // bus clock
  input  wire logic reset_in,   // sync reset, active high
  input  wire logic trigger_in, // start tracing
  output logic      begun_out,  // tracing under way
  output logic      line_out,   // one line stored, pulse
  output logic      done_out    // tracing complete, pulse
);
  int n;  // cycles spent tracing
  // ----------------------------------------
  // trace sequencing
  // ----------------------------------------
  // a line every other cycle, then one completion pulse
  always_ff @(posedge clk_in) begin
    line_out <= 1'b0;
    done_out <= 1'b0;
    if (reset_in) begin
      begun_out <= 1'b0;
      n <= 0;
    end else if (trigger_in && !begun_out) begin
      begun_out <= 1'b1;
      n <= 0;
    end else if (begun_out && n < 2 * LINES) begin
      line_out <= n[0];
      n <= n + 1;
    end else if (begun_out) begin
      done_out <= 1'b1;
      begun_out <= 1'b0;
    end
  end
endmodule : trace_partner
`default_nettype wire

// ---- sim/debug_session_control_tb.sv ----
// self-checking bench for debug_session_control with scoreboarded reads
// assumes the package, the design and trace_partner are compiled first
`timescale 1ns/1ps
`default_nettype none
module debug_session_control_tb;
  localparam int LINES = 4;  // short trace keeps the run brief
  logic clk = 1'b0, reset_in = 1'b1, por_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, rd_q = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, exp_q[$];
  logic secure_in = 1'b0, src_in = 1'b0, align_in = 1'b0, step_in = 1'b0, bme_in = 1'b0, act_in = 1'b0;
  logic [2:0] state_out;
  logic [1:0] bank_out;
  logic begun, done, line, armed_out, immediate_trigger_out, bg_out, swi_out, irq_out, win_out, shr_out, mview_out, ebg, eswi;
  int fails = 0, samples_checked = 0, immediate_trigger_n = 0, bg_n = 0, swi_n = 0, t, s, b, r;
  debug_session_control #(.LINES(LINES)) i_debug_session_control (.clk_in(clk), .reset_in(reset_in),
    .por_in(por_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .secure_in(secure_in), .trace_source_enable_in(src_in),
    .trigger_alignment_in(align_in), .trace_begun_in(begun), .trace_done_in(done), .trace_line_in(line),
    .seq_step_in(step_in), .seq_step_state_in(3'h4), .background_mode_enable_in(bme_in),
    .background_active_in(act_in), .armed_out(armed_out), .state_out(state_out), .bank_select_out(bank_out),
    .window_sel_out(win_out), .shared_sel_out(shr_out), .match_view_out(mview_out), .trigger_out(immediate_trigger_out),
    .background_out(bg_out), .software_int_out(swi_out), .irq_out(irq_out));
  trace_partner #(.LINES(LINES)) i_trace_partner (.clk_in(clk), .reset_in(reset_in), .trigger_in(immediate_trigger_out),
    .begun_out(begun), .line_out(line), .done_out(done));
  always #25 clk = ~clk;  // 20 MHz
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk);
    wr_in <= 1'b0;
  endtask : wr
  // read and note the expected data for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_in <= 1'b1;
    addr_in <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd_in <= 1'b0;
  endtask : rd
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause
  task automatic tally_and_finish;
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd_in;
    if (rd_q) check(rdata_out, exp_q.pop_front());
    immediate_trigger_n <= immediate_trigger_n + int'(immediate_trigger_out);
    bg_n <= bg_n + int'(bg_out);
    swi_n <= swi_n + int'(swi_out);
  end
  // arm with cfg and step the sequencer into its final state; the loop checks routed outputs per combination
  task automatic arm_and_step(input logic [7:0] cfg);
    wr(8'h20, 8'h00);
    wr(8'h20, cfg);
    wr(8'h20, cfg | 8'h80);
    t = bg_n;
    s = swi_n;
    step_in <= 1'b1;
    @(posedge clk);
    step_in <= 1'b0;
    pause(5);
  endtask : arm_and_step
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(32'habc8);
    pause(8);
    reset_in <= 1'b0;
    por_in <= 1'b0;
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h40, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h20, 8'(k));
      addr_in <= 8'(8'h27 + k);  // shared address, then window bytes
      pause(1);
      check(8'(bank_out), 8'(k));
      check(8'(win_out), 8'(k == 1 || k == 2));
      check(8'(shr_out), 8'(k == 0));
      check(8'(mview_out), 8'(k == 3));
    end
    wr(8'h20, 8'h5b);
    rd(8'h20, 8'h1b);
    wr(8'h20, 8'h98);
    rd(8'h21, 8'h01);
    wr(8'h20, 8'h80);
    wr(8'h21, 8'hff);
    rd(8'h20, 8'h98);
    rd(8'h21, 8'h01);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h18);
    rd(8'h21, 8'h01);
    for (int i = 0; i < 8; i++) begin
      b = $urandom % 4;
      bme_in <= i[1];
      act_in <= i[0];
      ebg = i[2] & i[1];
      eswi = i[2] ? !i[1] : !i[0];
      arm_and_step({3'h0, i[2], 2'h2, b[1:0]});
      check(8'(bg_n - t), 8'(ebg));
      check(8'(swi_n - s), 8'(eswi));
      if (ebg | eswi) check({armed_out, 4'h0, state_out}, 8'h00);
    end
    rd(8'h30, 8'h03);
    bme_in <= 1'b0;
    act_in <= 1'b0;
    wr(8'h31, 8'h07);
    arm_and_step(8'h18);
    check(8'(irq_out), 8'h01);
    rd(8'h30, 8'h03);
    pause(2);
    check(8'(irq_out), 8'h00);
    src_in <= 1'b1;
    arm_and_step(8'h00);
    wr(8'h20, 8'h80);
    t = immediate_trigger_n;
    s = swi_n;
    wr(8'h20, 8'hc0);
    pause(1);
    check(8'(state_out), 8'h04);
    align_in <= 1'b1;  // begin-aligned trace under way ignores this trigger
    wr(8'h20, 8'hc0);
    pause(2 * LINES + 8);
    check(8'(immediate_trigger_n - t), 8'h01);
    check(8'(swi_n - s), 8'h01);
    rd(8'h21, 8'h80);
    reset_in <= 1'b1;
    @(posedge clk);
    reset_in <= 1'b0;
    rd(8'h21, 8'h80);
    wr(8'h20, 8'h80);
    rd(8'h21, 8'h01);
    for (int j = 0; j < 2; j++) begin
      secure_in <= (j == 0);
      src_in <= (j == 0);
      wr(8'h20, 8'h80);
      t = immediate_trigger_n;
      s = swi_n;
      wr(8'h20, 8'hc0);
      pause(5);
      check(8'(immediate_trigger_n - t), 8'h00);
      check(8'(swi_n - s), 8'h01);
      check(8'(armed_out), 8'h00);
    end
    pause(3);
    tally_and_finish();
  end
  // hang guard, well beyond the expected run length
  initial begin
    pause(20000);
    fails++;
    tally_and_finish();
  end
endmodule : debug_session_control_tb
`default_nettype wire
